// File: hw/flash_op_status_register.sv
// Operation status word, clear/read-status commands and per-partition read modes
`timescale 1ns/1ps
module flash_op_status_register (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  // Host bus, already in this clock domain
  input  wire logic                   i_bus_write,
  input  wire logic                   i_bus_read,
  input  wire logic [2:0]             i_bus_partition,
  input  wire logic [15:0]            i_bus_wdata,
  input  wire logic [15:0]            i_array_rdata,
  // Program/erase engine status
  input  wire logic                   i_engine_busy,
  input  wire logic [2:0]             i_engine_partition,
  input  wire logic                   i_erase_suspended,
  input  wire logic                   i_program_suspended,
  input  wire logic                   i_factory_program_active,
  // Engine error events, one-cycle pulses
  input  wire logic                   i_err_program,
  input  wire logic                   i_err_erase,
  input  wire logic                   i_err_sequence,
  input  wire logic                   i_err_lock,
  input  wire logic                   i_err_region_ctrl,
  input  wire logic                   i_err_region_rewrite,
  input  wire logic                   i_err_region_illegal,
  // Supply comparator pin, asynchronous
  input  wire logic                   i_supply_below_lockout,
  output logic [15:0]                 o_bus_rdata,
  output logic                        o_bus_rvalid,
  output logic                        o_suspend_request,
  output logic                        o_abort_request,
  output logic [15:0]                 o_op_status_word
);
  localparam int unsigned NP = flash_status_pkg::NUM_PARTITIONS;

  typedef struct packed {
    logic        supply_meta;
    logic        supply_sync;
    logic [1:0]  region_err;
    logic [1:0]  op_err;
    logic        supply_err;
    logic        lock_err;
    logic        busy_q;
    logic [15:0] rdata;
    logic        rvalid;
    logic        suspend_req;
    logic        abort_req;
    logic [15:0] status;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  flash_status_pkg::read_mode_t part_mode [NP];
  logic [NP-1:0]                set_status;
  logic [NP-1:0]                set_array;
  logic [NP-1:0]                set_other;

  logic        cmd_clear;
  logic        cmd_read_status;
  logic        cmd_auto_status;
  logic        cmd_read_array;
  logic        cmd_other_mode;
  logic        cmd_suspend;
  logic [15:0] status_now;
  logic        same_part;

  // Command decode; only a bare write of a known code has an effect
  always_comb begin
    cmd_clear       = i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_CLEAR_STATUS);
    cmd_read_status = i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_READ_STATUS);
    cmd_read_array  = i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_READ_ARRAY);
    cmd_suspend     = i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_SUSPEND);
    cmd_auto_status = i_bus_write &&
                      ((i_bus_wdata == flash_status_pkg::CMD_WORD_PROGRAM) ||
                       (i_bus_wdata == flash_status_pkg::CMD_BUF_PROGRAM)  ||
                       (i_bus_wdata == flash_status_pkg::CMD_FACTORY_PROG) ||
                       (i_bus_wdata == flash_status_pkg::CMD_BLOCK_ERASE)  ||
                       (i_bus_wdata == flash_status_pkg::CMD_BLANK_CHECK)  ||
                       (i_bus_wdata == flash_status_pkg::CMD_CONFIG_SETUP));
    cmd_other_mode  = 1'b0;
  end

  // Per-partition mode strobes; other partitions see nothing
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      set_status[p] = (i_bus_partition == p[2:0]) &&
                      (cmd_clear || cmd_read_status || cmd_auto_status);
      set_array[p]  = (i_bus_partition == p[2:0]) && cmd_read_array;
      set_other[p]  = (i_bus_partition == p[2:0]) && cmd_other_mode;
    end
  end

  for (genvar g = 0; g < NP; g++) begin : g_part
    partition_read_mode u_mode (
      .i_clk_sys    (i_clk_sys),
      .i_reset      (i_reset),
      .i_set_status (set_status[g]),
      .i_set_array  (set_array[g]),
      .i_set_other  (set_other[g]),
      .o_mode       (part_mode[g])
    );
  end

  assign same_part = (i_engine_partition == i_bus_partition);

  // Status word assembled from live state and sticky errors
  always_comb begin
    status_now = '0;
    status_now[flash_status_pkg::BIT_REGION_HI:flash_status_pkg::BIT_REGION_LO] = state_ff.region_err;
    status_now[flash_status_pkg::BIT_READY]      = ~i_engine_busy;
    status_now[flash_status_pkg::BIT_ERASE_SUSP] = i_erase_suspended;
    status_now[flash_status_pkg::BIT_ERASE_ERR]  = state_ff.op_err[1];
    status_now[flash_status_pkg::BIT_PROG_ERR]   = state_ff.op_err[0];
    status_now[flash_status_pkg::BIT_SUPPLY_ERR] = state_ff.supply_err;
    status_now[flash_status_pkg::BIT_PROG_SUSP]  = i_program_suspended;
    status_now[flash_status_pkg::BIT_LOCK_ERR]   = state_ff.lock_err;
    // In factory programming bit zero shows the engine's own progress
    if (i_factory_program_active) begin
      status_now[flash_status_pkg::BIT_PART_STATUS] = i_engine_busy;
    end else begin
      status_now[flash_status_pkg::BIT_PART_STATUS] = i_engine_busy && !same_part;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.supply_meta = i_supply_below_lockout;
    nxt_state.supply_sync = state_ff.supply_meta;
    nxt_state.busy_q      = i_engine_busy;

    // Clear first, so an event in the same cycle still sets its flag
    if (cmd_clear) begin
      nxt_state.region_err = flash_status_pkg::REGION_OK;
      nxt_state.op_err     = 2'h0;
      nxt_state.supply_err = 1'b0;
      nxt_state.lock_err   = 1'b0;
    end

    // Error flags only ever set by hardware
    if (i_err_region_illegal) begin
      nxt_state.region_err = nxt_state.region_err | flash_status_pkg::REGION_ILLEGAL;
    end
    if (i_err_region_ctrl) begin
      nxt_state.region_err = nxt_state.region_err | flash_status_pkg::REGION_CTRL_WRITE;
    end
    if (i_err_region_rewrite) begin
      nxt_state.region_err = nxt_state.region_err | flash_status_pkg::REGION_REWRITE;
    end
    if (i_err_region_illegal || i_err_region_ctrl || i_err_region_rewrite || i_err_program) begin
      nxt_state.op_err = nxt_state.op_err | flash_status_pkg::OPERR_PROGRAM;
    end
    if (i_err_erase) begin
      nxt_state.op_err = nxt_state.op_err | flash_status_pkg::OPERR_ERASE;
    end
    if (i_err_sequence) begin
      nxt_state.op_err = flash_status_pkg::OPERR_SEQUENCE;
    end
    if (i_err_lock) begin
      nxt_state.lock_err = 1'b1;
    end
    // Supply loss only matters while an operation runs
    if (state_ff.supply_sync && i_engine_busy) begin
      nxt_state.supply_err = 1'b1;
    end

    nxt_state.abort_req   = state_ff.supply_sync && i_engine_busy;
    nxt_state.suspend_req = cmd_suspend && i_engine_busy;

    // Reads follow the addressed partition's mode
    nxt_state.rvalid = i_bus_read;
    if (part_mode[i_bus_partition] == flash_status_pkg::MODE_STATUS) begin
      nxt_state.rdata = status_now;
    end else begin
      nxt_state.rdata = i_array_rdata;
    end
    nxt_state.status = status_now;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_ff <= '{supply_meta: 1'b0, supply_sync: 1'b0, region_err: 2'h0, op_err: 2'h0,
                    supply_err: 1'b0, lock_err: 1'b0, busy_q: 1'b0, rdata: 16'h0000,
                    rvalid: 1'b0, suspend_req: 1'b0, abort_req: 1'b0,
                    status: flash_status_pkg::STATUS_RESET};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_bus_rdata       = state_ff.rdata;
  assign o_bus_rvalid      = state_ff.rvalid;
  assign o_suspend_request = state_ff.suspend_req;
  assign o_abort_request   = state_ff.abort_req;
  assign o_op_status_word  = state_ff.status;

  // Assertions
  sequence s_clear_cmd;
    i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_CLEAR_STATUS);
  endsequence

  sequence s_no_new_errors;
    !i_err_program && !i_err_erase && !i_err_sequence && !i_err_lock &&
    !i_err_region_ctrl && !i_err_region_rewrite && !i_err_region_illegal && !state_ff.supply_sync;
  endsequence

  property p_reserved_zero;
    @(posedge i_clk_sys) disable iff (i_reset) o_op_status_word[15:10] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits nonzero");

  property p_reset_value;
    @(posedge i_clk_sys) $fell(i_reset) |-> o_op_status_word == flash_status_pkg::STATUS_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("status not 0080h after reset");

  property p_clear_errors;
    @(posedge i_clk_sys) disable iff (i_reset)
      (s_clear_cmd and s_no_new_errors) ##1 s_no_new_errors |=>
      (o_op_status_word[9:8] == 2'h0) && (o_op_status_word[5:4] == 2'h0) &&
      !o_op_status_word[3] && !o_op_status_word[1];
  endproperty
  a_clear_errors: assert property (p_clear_errors) else $error("clear did not zero error bits");

  property p_lock_sticky;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_err_lock ##1 !(s_clear_cmd) [*3] |=> o_op_status_word[1];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock error flag lost");

  property p_region_sets_bit4;
    @(posedge i_clk_sys) disable iff (i_reset)
      o_op_status_word[9:8] != 2'h0 |-> o_op_status_word[4];
  endproperty
  a_region_sets_bit4: assert property (p_region_sets_bit4) else $error("region error without bit4");

  property p_ready_bit;
    @(posedge i_clk_sys) disable iff (i_reset)
      ##1 o_op_status_word[7] == !$past(i_engine_busy);
  endproperty
  a_ready_bit: assert property (p_ready_bit) else $error("ready bit wrong");

  property p_suspend_bits;
    @(posedge i_clk_sys) disable iff (i_reset)
      ##1 (o_op_status_word[6] == $past(i_erase_suspended)) &&
          (o_op_status_word[2] == $past(i_program_suspended));
  endproperty
  a_suspend_bits: assert property (p_suspend_bits) else $error("suspend bits wrong");

  property p_status_read;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_READ_STATUS) ##1
      (i_bus_read && !i_bus_write && $stable(i_bus_partition)) |=> o_bus_rdata == o_op_status_word;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read returned other data");

  property p_supply_err;
    @(posedge i_clk_sys) disable iff (i_reset)
      state_ff.supply_sync && i_engine_busy |=> o_abort_request ##1 o_op_status_word[3];
  endproperty
  a_supply_err: assert property (p_supply_err) else $error("supply lockout not flagged");

  property p_no_reserved_code;
    @(posedge i_clk_sys) disable iff (i_reset)
      !i_factory_program_active |=> !(o_op_status_word[7] && o_op_status_word[0]);
  endproperty
  a_no_reserved_code: assert property (p_no_reserved_code) else $error("reserved bit7/bit0 code");

  // A read right behind a mode command, to the same partition
  sequence s_read_same_part;
    i_bus_read && !i_bus_write && $stable(i_bus_partition);
  endsequence

  property p_clear_to_status;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_clear_cmd ##1 s_read_same_part |=> o_bus_rdata == o_op_status_word;
  endproperty
  a_clear_to_status: assert property (p_clear_to_status) else $error("clear did not select status");

  property p_auto_status;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_WORD_PROGRAM) ##1 s_read_same_part |=>
      o_bus_rdata == o_op_status_word;
  endproperty
  a_auto_status: assert property (p_auto_status) else $error("program did not select status");

  property p_array_read;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_READ_ARRAY) ##1 s_read_same_part |=>
      o_bus_rdata == $past(i_array_rdata);
  endproperty
  a_array_read: assert property (p_array_read) else $error("array read returned other data");

  property p_sequence_code;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_err_sequence |-> ##2 o_op_status_word[5:4] == 2'h3;
  endproperty
  a_sequence_code: assert property (p_sequence_code) else $error("sequence error code wrong");

  property p_program_err;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_err_program |-> ##2 o_op_status_word[4];
  endproperty
  a_program_err: assert property (p_program_err) else $error("program error not flagged");

  property p_lock_set;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_err_lock |-> ##2 o_op_status_word[1];
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock error not flagged");

  property p_region_code;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_err_region_ctrl && !i_err_region_rewrite && !i_err_region_illegal |-> ##2 o_op_status_word[9];
  endproperty
  a_region_code: assert property (p_region_code) else $error("region error code wrong");

  property p_suspend_pulse;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_bus_write && (i_bus_wdata == flash_status_pkg::CMD_SUSPEND) && i_engine_busy |=> o_suspend_request;
  endproperty
  a_suspend_pulse: assert property (p_suspend_pulse) else $error("suspend not requested");

  property p_abort_quiet;
    @(posedge i_clk_sys) disable iff (i_reset)
      !(state_ff.supply_sync && i_engine_busy) |=> !o_abort_request;
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("abort without supply loss");

  property p_reset_outputs;
    @(posedge i_clk_sys) $fell(i_reset) |-> !o_bus_rvalid && !o_suspend_request && !o_abort_request;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs active after reset");
endmodule

// File: hw/flash_status_pkg.sv
// Constants for the flash operation status word and its command decode
package flash_status_pkg;
  localparam int unsigned        NUM_PARTITIONS    = 8;
  localparam int unsigned        PART_SEL_W        = 3;
  localparam int unsigned        STATUS_W          = 16;
  localparam logic [15:0]        STATUS_RESET      = 16'h0080;
  // Command codes on the data bus
  localparam logic [15:0]        CMD_CLEAR_STATUS  = 16'h0050;
  localparam logic [15:0]        CMD_READ_STATUS   = 16'h0070;
  localparam logic [15:0]        CMD_READ_ARRAY    = 16'h00ff;
  localparam logic [15:0]        CMD_SUSPEND       = 16'h00b0;
  localparam logic [15:0]        CMD_WORD_PROGRAM  = 16'h0041;
  localparam logic [15:0]        CMD_BUF_PROGRAM   = 16'h00e9;
  localparam logic [15:0]        CMD_FACTORY_PROG  = 16'h0080;
  localparam logic [15:0]        CMD_BLOCK_ERASE   = 16'h0020;
  localparam logic [15:0]        CMD_BLANK_CHECK   = 16'h00bc;
  localparam logic [15:0]        CMD_CONFIG_SETUP  = 16'h0060;
  // Field positions of the status word
  localparam int unsigned        BIT_PART_STATUS   = 0;
  localparam int unsigned        BIT_LOCK_ERR      = 1;
  localparam int unsigned        BIT_PROG_SUSP     = 2;
  localparam int unsigned        BIT_SUPPLY_ERR    = 3;
  localparam int unsigned        BIT_PROG_ERR      = 4;
  localparam int unsigned        BIT_ERASE_ERR     = 5;
  localparam int unsigned        BIT_ERASE_SUSP    = 6;
  localparam int unsigned        BIT_READY         = 7;
  localparam int unsigned        BIT_REGION_LO     = 8;
  localparam int unsigned        BIT_REGION_HI     = 9;
  // Region program error codes, {bit9, bit8}
  localparam logic [1:0]         REGION_OK         = 2'h0;
  localparam logic [1:0]         REGION_CTRL_WRITE = 2'h2;
  localparam logic [1:0]         REGION_REWRITE    = 2'h1;
  localparam logic [1:0]         REGION_ILLEGAL    = 2'h3;
  // Operation error codes, {bit5, bit4}
  localparam logic [1:0]         OPERR_PROGRAM     = 2'h1;
  localparam logic [1:0]         OPERR_ERASE       = 2'h2;
  localparam logic [1:0]         OPERR_SEQUENCE    = 2'h3;
  typedef enum logic [1:0] {
    MODE_ARRAY,
    MODE_STATUS,
    MODE_OTHER
  } read_mode_t;
endpackage

// File: hw/partition_read_mode.sv
// One partition's read-mode tracker
`timescale 1ns/1ps
module partition_read_mode (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_reset,
  input  wire logic                      i_set_status,
  input  wire logic                      i_set_array,
  input  wire logic                      i_set_other,
  output flash_status_pkg::read_mode_t   o_mode
);
  typedef struct packed {
    flash_status_pkg::read_mode_t mode;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (i_set_status) begin
      nxt_state.mode = flash_status_pkg::MODE_STATUS;
    end else if (i_set_array) begin
      nxt_state.mode = flash_status_pkg::MODE_ARRAY;
    end else if (i_set_other) begin
      nxt_state.mode = flash_status_pkg::MODE_OTHER;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_ff <= '{mode: flash_status_pkg::MODE_ARRAY};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_mode = state_ff.mode;
endmodule

// File: verification/flash_host_model.sv
// Host-side bus model that issues status commands and reads words back
`timescale 1ns/1ps
module flash_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_bus_rdata,
  input  wire logic        i_bus_rvalid,
  output logic             o_bus_write,
  output logic             o_bus_read,
  output logic [2:0]       o_bus_partition,
  output logic [15:0]      o_bus_wdata
);
  initial begin
    o_bus_write     = 1'b0;
    o_bus_read      = 1'b0;
    o_bus_partition = 3'h0;
    o_bus_wdata     = 16'h0000;
  end
  // A whole command travels in one write cycle; nothing follows it
  task automatic write_cmd(input logic [2:0] p, input logic [15:0] code);
    @(posedge i_clk_sys);
    o_bus_write     <= 1'b1;
    o_bus_partition <= p;
    o_bus_wdata     <= code;
    @(posedge i_clk_sys);
    o_bus_write <= 1'b0;
    // Released data bus shows the inverse so a stale code never looks valid
    o_bus_wdata <= ~code;
  endtask
  // Partition settles a cycle ahead of the strobe; the answer is awaited 3 edges
  task automatic read_word(input logic [2:0] p, output logic [15:0] d);
    d = 'x;
    @(posedge i_clk_sys);
    o_bus_partition <= p;
    @(posedge i_clk_sys);
    o_bus_read <= 1'b1;
    @(posedge i_clk_sys);
    o_bus_read <= 1'b0;
    for (int n = 0; n < 3; n++) begin
      #1;
      if (i_bus_rvalid === 1'b1) begin
        d = i_bus_rdata;
        break;
      end
      @(posedge i_clk_sys);
    end
  endtask
  // Command and a read right behind it, to the same partition
  task automatic cmd_read(input logic [2:0] p, input logic [15:0] code, output logic [15:0] d);
    d = 'x;
    @(posedge i_clk_sys);
    o_bus_write     <= 1'b1;
    o_bus_partition <= p;
    o_bus_wdata     <= code;
    @(posedge i_clk_sys);
    o_bus_write <= 1'b0;
    o_bus_wdata <= ~code;
    o_bus_read  <= 1'b1;
    @(posedge i_clk_sys);
    o_bus_read <= 1'b0;
    #1;
    if (i_bus_rvalid === 1'b1) begin
      d = i_bus_rdata;
    end
  endtask
endmodule

// File: verification/flash_op_status_register_bench.sv
// Self-checking bench for the flash operation status word
`timescale 1ns/1ps
module flash_op_status_register_bench;
  logic        i_clk_sys;
  logic        i_reset;
  logic        bus_write, bus_read, rvalid, susp_req, abort_req;
  logic [2:0]  bus_partition, engine_partition;
  logic [15:0] bus_wdata, rdata, status;
  logic [15:0] array_rdata;
  logic        engine_busy, erase_susp, prog_susp, factory_active, supply_low;
  logic [6:0]  err_v;
  int          n_mismatch;
  int          cmp_count;

  flash_host_model host_u (
    .i_clk_sys       (i_clk_sys),
    .i_bus_rdata     (rdata),
    .i_bus_rvalid    (rvalid),
    .o_bus_write     (bus_write),
    .o_bus_read      (bus_read),
    .o_bus_partition (bus_partition),
    .o_bus_wdata     (bus_wdata)
  );

  flash_op_status_register dut_u (
    .i_clk_sys                (i_clk_sys),
    .i_reset                  (i_reset),
    .i_bus_write              (bus_write),
    .i_bus_read               (bus_read),
    .i_bus_partition          (bus_partition),
    .i_bus_wdata              (bus_wdata),
    .i_array_rdata            (array_rdata),
    .i_engine_busy            (engine_busy),
    .i_engine_partition       (engine_partition),
    .i_erase_suspended        (erase_susp),
    .i_program_suspended      (prog_susp),
    .i_factory_program_active (factory_active),
    .i_err_program            (err_v[0]),
    .i_err_erase              (err_v[1]),
    .i_err_sequence           (err_v[2]),
    .i_err_lock               (err_v[3]),
    .i_err_region_ctrl        (err_v[4]),
    .i_err_region_rewrite     (err_v[5]),
    .i_err_region_illegal     (err_v[6]),
    .i_supply_below_lockout   (supply_low),
    .o_bus_rdata              (rdata),
    .o_bus_rvalid             (rvalid),
    .o_suspend_request        (susp_req),
    .o_abort_request          (abort_req),
    .o_op_status_word         (status)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic rd_check(input logic [2:0] p, input logic [15:0] exp);
    logic [15:0] d;
    host_u.read_word(p, d);
    check(d, exp);
  endtask

  task automatic cr_check(input logic [2:0] p, input logic [15:0] code, input logic [15:0] exp);
    logic [15:0] d;
    host_u.cmd_read(p, code, d);
    check(d, exp);
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge i_clk_sys);
    err_v <= v;
    @(posedge i_clk_sys);
    err_v <= 7'h00;
    step(2);
  endtask

  task automatic t_modes();
    logic [15:0] codes [6] = '{16'h0041, 16'h00e9, 16'h0080, 16'h0020, 16'h00bc, 16'h0060};
    rd_check(3'h0, 16'h5a3c);
    host_u.write_cmd(3'h1, flash_status_pkg::CMD_READ_STATUS);
    rd_check(3'h1, 16'h0080);
    rd_check(3'h0, 16'h5a3c);
    host_u.write_cmd(3'h4, flash_status_pkg::CMD_CLEAR_STATUS);
    rd_check(3'h4, 16'h0080);
    rd_check(3'h0, 16'h5a3c);
    for (int i = 0; i < 6; i++) begin
      host_u.write_cmd(3'h6, flash_status_pkg::CMD_READ_ARRAY);
      rd_check(3'h6, 16'h5a3c);
      host_u.write_cmd(3'h6, codes[i]);
      rd_check(3'h6, 16'h0080);
    end
    cr_check(3'h7, flash_status_pkg::CMD_READ_STATUS, 16'h0080);
    cr_check(3'h7, flash_status_pkg::CMD_READ_ARRAY, 16'h5a3c);
    cr_check(3'h7, flash_status_pkg::CMD_WORD_PROGRAM, 16'h0080);
    cr_check(3'h7, flash_status_pkg::CMD_READ_ARRAY, 16'h5a3c);
    cr_check(3'h7, flash_status_pkg::CMD_CLEAR_STATUS, 16'h0080);
  endtask

  task automatic t_errors();
    logic [15:0] exp_tab [7] = '{16'h0090, 16'h00a0, 16'h00b0, 16'h0082, 16'h0290, 16'h0190, 16'h0390};
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      check(status, exp_tab[i]);
      host_u.write_cmd(3'(i), 16'h1234);
      step(2);
      check(status, exp_tab[i]);
      host_u.write_cmd(3'(i), flash_status_pkg::CMD_CLEAR_STATUS);
      step(2);
      check(status, flash_status_pkg::STATUS_RESET);
    end
    // Reset in mid-run must wipe a sticky flag and partition 1's read mode
    pulse(7'h08);
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_reset <= 1'b0;
    step(2);
    check(status, 16'h0080);
    rd_check(3'h1, 16'h5a3c);
  endtask

  task automatic t_busy();
    host_u.write_cmd(3'h2, flash_status_pkg::CMD_READ_STATUS);
    host_u.write_cmd(3'h5, flash_status_pkg::CMD_READ_STATUS);
    @(posedge i_clk_sys);
    engine_busy      <= 1'b1;
    engine_partition <= 3'h2;
    rd_check(3'h2, 16'h0000);
    rd_check(3'h5, 16'h0001);
    @(posedge i_clk_sys);
    factory_active <= 1'b1;
    rd_check(3'h2, 16'h0001);
    @(posedge i_clk_sys);
    engine_busy    <= 1'b0;
    factory_active <= 1'b0;
    rd_check(3'h5, 16'h0080);
  endtask

  task automatic t_suspend();
    logic seen;
    seen = 1'b0;
    @(posedge i_clk_sys);
    engine_busy <= 1'b1;
    host_u.write_cmd(3'h3, flash_status_pkg::CMD_SUSPEND);
    for (int n = 0; n < 3; n++) begin
      #1;
      if (susp_req === 1'b1) seen = 1'b1;
      @(posedge i_clk_sys);
    end
    check(16'(seen), 16'h0001);
    engine_busy <= 1'b0;
    erase_susp  <= 1'b1;
    step(3);
    check(status, 16'h00c0);
    pulse(7'h04);
    check(status, 16'h00f0);
    // Host clears before resuming so later erase errors stay visible
    host_u.write_cmd(3'h0, flash_status_pkg::CMD_CLEAR_STATUS);
    step(2);
    check(status, 16'h00c0);
    @(posedge i_clk_sys);
    erase_susp <= 1'b0;
    prog_susp  <= 1'b1;
    step(3);
    check(status, 16'h0084);
    prog_susp <= 1'b0;
  endtask

  task automatic t_supply();
    @(posedge i_clk_sys);
    engine_busy <= 1'b1;
    supply_low  <= 1'b1;
    step(6);
    check(status & 16'h0088, 16'h0008);
    check(16'(abort_req), 16'h0001);
    engine_busy <= 1'b0;
    step(3);
    check(status, 16'h0088);
    host_u.write_cmd(3'h1, flash_status_pkg::CMD_CLEAR_STATUS);
    step(2);
    check(status, 16'h0080);
    supply_low <= 1'b0;
  endtask

  initial begin
    n_mismatch       = 0;
    cmp_count        = 0;
    i_reset          = 1'b1;
    array_rdata      = 16'h5a3c;
    engine_busy      = 1'b0;
    engine_partition = 3'h0;
    erase_susp       = 1'b0;
    prog_susp        = 1'b0;
    factory_active   = 1'b0;
    supply_low       = 1'b0;
    err_v            = 7'h00;
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    step(1);
    check(status, flash_status_pkg::STATUS_RESET);
    t_modes();
    t_errors();
    t_busy();
    t_suspend();
    t_supply();
    print_verdict();
  end

  // The sequence takes well under 2000 cycles; ten times that means a hang
  initial begin
    #(40 * 20000);
    n_mismatch++;
    print_verdict();
  end
endmodule
